// ===== core/gpm_pkg.sv
// Purpose: Shared constants and carrier types for the dual port pin multiplexer.
// Assumes: Classic Wishbone register access with 32-bit data and byte addresses.
// Notes:   Every register sits in the low byte of one aligned word.
package gpm_pkg;

    // Register bus geometry.
    localparam int          ADR_W       = 8;
    localparam int          DAT_W       = 32;
    localparam int          SEL_W       = 4;

    // Register byte offsets.
    localparam logic [7:0]  OFS_C_PIN   = 8'h00;
    localparam logic [7:0]  OFS_C_LAT   = 8'h04;
    localparam logic [7:0]  OFS_C_DIR   = 8'h08;
    localparam logic [7:0]  OFS_D_PIN   = 8'h0C;
    localparam logic [7:0]  OFS_D_LAT   = 8'h10;
    localparam logic [7:0]  OFS_D_DIR   = 8'h14;
    localparam logic [7:0]  OFS_CFG     = 8'h18;

    // Reset values; a direction bit of one means input.
    localparam logic [7:0]  DIR_RST     = 8'hFF;
    localparam logic [4:0]  CFG_RST     = 5'h00;
    localparam logic [7:0]  HIZ_ALL     = 8'hFF;

    // Location select field positions in the configuration register.
    localparam int          CFG_SSP     = 0;
    localparam int          CFG_EXCLK   = 1;
    localparam int          CFG_PWM_FAULT_A_INPUT    = 2;
    localparam int          CFG_PWM4    = 3;
    localparam int          CFG_CAPTURE_COMPARE_UNIT2    = 4;
    localparam int          CFG_W       = 5;

    // Bank C pin positions of the routed functions.
    localparam int          C_T1        = 0;
    localparam int          C_CAPTURE_COMPARE_UNIT2      = 1;
    localparam int          C_CAPTURE_COMPARE_UNIT1      = 2;
    localparam int          C_EXTERNAL_INTERRUPT_0      = 3;
    localparam int          C_SDA       = 4;
    localparam int          C_SCK       = 5;
    localparam int          C_TX        = 6;
    localparam int          C_RX        = 7;

    // Bank D pin positions of the routed functions.
    localparam int          D_EXCLK     = 0;
    localparam int          D_SDO       = 1;
    localparam int          D_SDA       = 2;
    localparam int          D_SCK       = 3;
    localparam int          D_PWM_FAULT_A_INPUT      = 4;
    localparam int          D_PWM4      = 5;
    localparam int          D_PWM6      = 6;
    localparam int          D_PWM7      = 7;

    // One bank of pins as driven out: active low enable and value.
    typedef struct packed {
        logic [7:0] oe_n;
        logic [7:0] val;
    } gpm_pins_t;

    // Requests from the on-chip peripherals that want pins.
    typedef struct packed {
        logic       t1osc_en;
        logic       capture_compare_unit1_oe;
        logic       capture_compare_unit1_o;
        logic       capture_compare_unit2_oe;
        logic       capture_compare_unit2_o;
        logic       ssp_en;
        logic       sdo_oe;
        logic       sdo;
        logic       sck_oe;
        logic       sck;
        logic       sda_oe;
        logic       sda;
        logic       uart_en;
        logic       tx_oe;
        logic       tx;
        logic       dt_oe;
        logic       dt;
        logic [2:0] pwm_en;
        logic [2:0] pwm;
    } gpm_per_drv_t;

    // Pin levels handed to the peripherals.
    typedef struct packed {
        logic [2:0] ext_int;
        logic       t0_clk;
        logic       t5_clk;
        logic       t1_clk;
        logic       t1_osc_in;
        logic       capture_compare_unit1_in;
        logic       capture_compare_unit2_in;
        logic       fault_a;
        logic       fault_b;
        logic       sdi;
        logic       sck_in;
        logic       ss;
        logic       rx;
        logic       ck_in;
    } gpm_per_rcv_t;

endpackage : gpm_pkg

// ===== core/gpm_port.sv
// Purpose: Two eight-bit bidirectional ports with peripheral pin routing.
// Assumes: Single 100 MHz clock, synchronous active high reset, classic Wishbone.
// Notes:   Output latches and pin samplers carry no reset so values survive soft resets.
//
// What this block does
// - Bank C direction one floats the pin.
// - Bank C direction zero drives latch value.
// - Bank C latch readable, reads latch not pins.
// - Bank D eight pins, per-bit direction.
// - Bank D latch readable, reads latch not pins.
// - All pins inputs; directions all ones after reset.
// - Enabled peripherals override bank C direction.
// - Direction read returns stored, not overridden, value.
// - External interrupts 0-2 from C3, C4, C5.
// - Serial port on C4, C5, C7 primarily.
// - Alternate serial port on D1, D2, D3.
// - Serial transceiver receive C7, transmit C6.
// - C6 slave select, C7 serial data out.
// - Timer 0/5 clocks from C3 or D0.
// - Faults on C1, C2; fault A movable D4.
// - D6, D7 carry PWM outputs 6, 7.
// - PWM output 4 movable to D5.
// - C0, C1 serve timer 1 oscillator.
// - C1 carries capture-compare 2 by select.
// - C2 carries capture-compare 1.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module gpm_port (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [gpm_pkg::ADR_W-1:0]  wb_adr_i,
    input  wire logic [gpm_pkg::SEL_W-1:0]  wb_sel_i,
    input  wire logic [gpm_pkg::DAT_W-1:0]  wb_dat_i,
    output logic      [gpm_pkg::DAT_W-1:0]  wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic [7:0]                 pin_c_i,
    input  wire logic [7:0]                 pin_d_i,
    output gpm_pkg::gpm_pins_t              pin_c_o,
    output gpm_pkg::gpm_pins_t              pin_d_o,
    input  wire gpm_pkg::gpm_per_drv_t      per_drv_i,
    output gpm_pkg::gpm_per_rcv_t           per_rcv_o
);
    import gpm_pkg::*;

    // Replace the low byte when its lane is enabled.
    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [DAT_W-1:0] d,
                                           input logic [SEL_W-1:0] sel);
        wr_byte = sel[0] ? d[7:0] : old;
    endfunction : wr_byte

    // Combine the latch with a peripheral request into pin value and active low enable.
    function automatic logic [15:0] pin_mux(input logic [7:0] dir, input logic [7:0] lat,
                                            input logic [7:0] f_out, input logic [7:0] f_in,
                                            input logic [7:0] f_val);
        logic [7:0] drive;
        drive   = f_out | (~f_in & ~dir);
        pin_mux = {~drive, drive & ((f_out & f_val) | (~f_out & lat))};
    endfunction : pin_mux

    logic [7:0]       lat_c_r;
    logic [7:0]       lat_d_r;
    logic [7:0]       dir_c_r;
    logic [7:0]       dir_d_r;
    logic [CFG_W-1:0] cfg_r;
    logic [7:0]       sc1_r, sc2_r, sc3_r, lvl_c_r;
    logic [7:0]       sd1_r, sd2_r, sd3_r, lvl_d_r;
    logic [7:0]       fo_c, fi_c, fv_c;
    logic [7:0]       fo_d, fi_d, fv_d;
    logic [15:0]      mux_c, mux_d;
    logic             req;
    logic             wr_en;
    logic             ssp_c;
    logic             ssp_d;

    // A new request is taken once; the registered ack then closes it.
    assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = req && wb_we_i;

    // Ack one cycle after the request and drop it the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Read data is captured with the ack; unmapped offsets answer zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (req) begin
            unique case (wb_adr_i)
                OFS_C_PIN: wb_dat_o <= {24'h00_0000, lvl_c_r};
                OFS_C_LAT: wb_dat_o <= {24'h00_0000, lat_c_r};
                OFS_C_DIR: wb_dat_o <= {24'h00_0000, dir_c_r};
                OFS_D_PIN: wb_dat_o <= {24'h00_0000, lvl_d_r};
                OFS_D_LAT: wb_dat_o <= {24'h00_0000, lat_d_r};
                OFS_D_DIR: wb_dat_o <= {24'h00_0000, dir_d_r};
                OFS_CFG:   wb_dat_o <= {27'h000_0000, cfg_r};
                default:   wb_dat_o <= '0;
            endcase
        end
    end

    // Latches have no reset so their contents survive every reset but power loss.
    always_ff @(posedge clk_i) begin
        if (wr_en && (wb_adr_i == OFS_C_PIN || wb_adr_i == OFS_C_LAT)) begin
            lat_c_r <= wr_byte(lat_c_r, wb_dat_i, wb_sel_i);
        end
        if (wr_en && (wb_adr_i == OFS_D_PIN || wb_adr_i == OFS_D_LAT)) begin
            lat_d_r <= wr_byte(lat_d_r, wb_dat_i, wb_sel_i);
        end
    end

    // Direction registers return to all inputs on any reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_c_r <= DIR_RST;
            dir_d_r <= DIR_RST;
        end else begin
            if (wr_en && wb_adr_i == OFS_C_DIR) begin
                dir_c_r <= wr_byte(dir_c_r, wb_dat_i, wb_sel_i);
            end
            if (wr_en && wb_adr_i == OFS_D_DIR) begin
                dir_d_r <= wr_byte(dir_d_r, wb_dat_i, wb_sel_i);
            end
        end
    end

    // Location selects; zero keeps every function but PWM output 4 at its primary pin, and PWM output 4 then drives no pin.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= CFG_RST;
        end else if (wr_en && wb_adr_i == OFS_CFG && wb_sel_i[0]) begin
            cfg_r <= wb_dat_i[CFG_W-1:0];
        end
    end

    // Pins are asynchronous; three stages, and a level counts once stages two and three agree.
    always_ff @(posedge clk_i) begin
        sc1_r <= pin_c_i;
        sc2_r <= sc1_r;
        sc3_r <= sc2_r;
        sd1_r <= pin_d_i;
        sd2_r <= sd1_r;
        sd3_r <= sd2_r;
        for (int i = 0; i < 8; i++) begin
            if (sc2_r[i] == sc3_r[i]) begin
                lvl_c_r[i] <= sc3_r[i];
            end
            if (sd2_r[i] == sd3_r[i]) begin
                lvl_d_r[i] <= sd3_r[i];
            end
        end
    end

    assign ssp_c = per_drv_i.ssp_en && !cfg_r[CFG_SSP];
    assign ssp_d = per_drv_i.ssp_en &&  cfg_r[CFG_SSP];

    // Bank C overrides: forced outputs, forced inputs and their values.
    always_comb begin
        fo_c = 8'h00;
        fi_c = 8'h00;
        fv_c = 8'h00;
        // The oscillator pins are analog; both are held off the port driver.
        fi_c[C_T1]   = per_drv_i.t1osc_en;
        fi_c[C_CAPTURE_COMPARE_UNIT2] = per_drv_i.t1osc_en;
        if (!cfg_r[CFG_CAPTURE_COMPARE_UNIT2] && per_drv_i.capture_compare_unit2_oe && !per_drv_i.t1osc_en) begin
            fo_c[C_CAPTURE_COMPARE_UNIT2] = 1'b1;
            fv_c[C_CAPTURE_COMPARE_UNIT2] = per_drv_i.capture_compare_unit2_o;
        end
        fo_c[C_CAPTURE_COMPARE_UNIT1] = per_drv_i.capture_compare_unit1_oe;
        fv_c[C_CAPTURE_COMPARE_UNIT1] = per_drv_i.capture_compare_unit1_o;
        fo_c[C_SDA]  = ssp_c && per_drv_i.sda_oe;
        fv_c[C_SDA]  = per_drv_i.sda;
        fo_c[C_SCK]  = ssp_c && per_drv_i.sck_oe;
        fv_c[C_SCK]  = per_drv_i.sck;
        fo_c[C_TX]   = per_drv_i.uart_en && per_drv_i.tx_oe;
        fv_c[C_TX]   = per_drv_i.tx;
        // The transceiver has priority on C7 over serial data out.
        if (per_drv_i.uart_en && per_drv_i.dt_oe) begin
            fo_c[C_RX] = 1'b1;
            fv_c[C_RX] = per_drv_i.dt;
        end else if (ssp_c && per_drv_i.sdo_oe) begin
            fo_c[C_RX] = 1'b1;
            fv_c[C_RX] = per_drv_i.sdo;
        end
    end

    // Bank D overrides: alternate serial port and PWM outputs.
    always_comb begin
        fo_d = 8'h00;
        fi_d = 8'h00;
        fv_d = 8'h00;
        fo_d[D_SDO]  = ssp_d && per_drv_i.sdo_oe;
        fv_d[D_SDO]  = per_drv_i.sdo;
        fo_d[D_SDA]  = ssp_d && per_drv_i.sda_oe;
        fv_d[D_SDA]  = per_drv_i.sda;
        fo_d[D_SCK]  = ssp_d && per_drv_i.sck_oe;
        fv_d[D_SCK]  = per_drv_i.sck;
        fo_d[D_PWM4] = cfg_r[CFG_PWM4] && per_drv_i.pwm_en[0];
        fv_d[D_PWM4] = per_drv_i.pwm[0];
        fo_d[D_PWM6] = per_drv_i.pwm_en[1];
        fv_d[D_PWM6] = per_drv_i.pwm[1];
        fo_d[D_PWM7] = per_drv_i.pwm_en[2];
        fv_d[D_PWM7] = per_drv_i.pwm[2];
    end

    assign mux_c = pin_mux(dir_c_r, lat_c_r, fo_c, fi_c, fv_c);
    assign mux_d = pin_mux(dir_d_r, lat_d_r, fo_d, fi_d, fv_d);

    // Pin drivers are registered; reset releases every pin.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_c_o <= '{oe_n: HIZ_ALL, val: 8'h00};
            pin_d_o <= '{oe_n: HIZ_ALL, val: 8'h00};
        end else begin
            pin_c_o <= '{oe_n: mux_c[15:8], val: mux_c[7:0]};
            pin_d_o <= '{oe_n: mux_d[15:8], val: mux_d[7:0]};
        end
    end

    // Sampled levels routed to the peripherals, selected by location bits.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_rcv_o <= '0;
        end else begin
            per_rcv_o.ext_int   <= lvl_c_r[C_EXTERNAL_INTERRUPT_0 +: 3];
            per_rcv_o.t0_clk    <= cfg_r[CFG_EXCLK] ? lvl_d_r[D_EXCLK] : lvl_c_r[C_EXTERNAL_INTERRUPT_0];
            per_rcv_o.t5_clk    <= cfg_r[CFG_EXCLK] ? lvl_d_r[D_EXCLK] : lvl_c_r[C_EXTERNAL_INTERRUPT_0];
            per_rcv_o.t1_clk    <= lvl_c_r[C_T1];
            per_rcv_o.t1_osc_in <= lvl_c_r[C_CAPTURE_COMPARE_UNIT2];
            per_rcv_o.capture_compare_unit1_in   <= lvl_c_r[C_CAPTURE_COMPARE_UNIT1];
            per_rcv_o.capture_compare_unit2_in   <= cfg_r[CFG_CAPTURE_COMPARE_UNIT2] ? 1'b0 : lvl_c_r[C_CAPTURE_COMPARE_UNIT2];
            per_rcv_o.fault_a   <= cfg_r[CFG_PWM_FAULT_A_INPUT] ? lvl_d_r[D_PWM_FAULT_A_INPUT] : lvl_c_r[C_CAPTURE_COMPARE_UNIT2];
            per_rcv_o.fault_b   <= lvl_c_r[C_CAPTURE_COMPARE_UNIT1];
            per_rcv_o.sdi       <= cfg_r[CFG_SSP] ? lvl_d_r[D_SDA] : lvl_c_r[C_SDA];
            per_rcv_o.sck_in    <= cfg_r[CFG_SSP] ? lvl_d_r[D_SCK] : lvl_c_r[C_SCK];
            per_rcv_o.ss        <= lvl_c_r[C_TX];
            per_rcv_o.rx        <= lvl_c_r[C_RX];
            per_rcv_o.ck_in     <= lvl_c_r[C_TX];
        end
    end

    // Checks on the pins, the register file and the routing.
    a_dir_reset: assert property (@(posedge clk_i) rst_i |=>
        dir_c_r == DIR_RST && dir_d_r == DIR_RST && pin_c_o.oe_n == HIZ_ALL
        && pin_d_o.oe_n == HIZ_ALL) else $error("Reset left a pin driven.");

    a_c_input_float: assert property (@(posedge clk_i) disable iff (rst_i)
        (dir_c_r[C_EXTERNAL_INTERRUPT_0] && per_drv_i == '0) |=> pin_c_o.oe_n[C_EXTERNAL_INTERRUPT_0])
        else $error("Bank C input pin is driven.");

    a_c_output_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (!dir_c_r[C_EXTERNAL_INTERRUPT_0] && per_drv_i == '0) |=>
        !pin_c_o.oe_n[C_EXTERNAL_INTERRUPT_0] && pin_c_o.val[C_EXTERNAL_INTERRUPT_0] == $past(lat_c_r[C_EXTERNAL_INTERRUPT_0]))
        else $error("Bank C output does not follow the latch.");

    a_d_output_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (!dir_d_r[0] && !cfg_r[CFG_SSP]) |=>
        !pin_d_o.oe_n[0] && pin_d_o.val[0] == $past(lat_d_r[0]))
        else $error("Bank D output does not follow the latch.");

    a_c_latch_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i == OFS_C_LAT) |=>
        wb_ack_o && wb_dat_o == {24'h00_0000, $past(lat_c_r)})
        else $error("Bank C latch read returned other data.");

    a_d_latch_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i == OFS_D_LAT) |=>
        wb_ack_o && wb_dat_o == {24'h00_0000, $past(lat_d_r)})
        else $error("Bank D latch read returned other data.");

    a_dir_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i == OFS_C_DIR) |=>
        wb_dat_o[7:0] == $past(dir_c_r)) else $error("Direction read shows override.");

    a_pin_write_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_en && wb_adr_i == OFS_C_PIN && wb_sel_i[0]) |=> lat_c_r == $past(wb_dat_i[7:0]))
        else $error("Pin register write missed the latch.");

    a_ext_int_route: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |=> per_rcv_o.ext_int == $past(lvl_c_r[5:3])) else $error("Interrupt routing wrong.");

    a_alt_ssp_out: assert property (@(posedge clk_i) disable iff (rst_i)
        (ssp_d && per_drv_i.sdo_oe) |=>
        !pin_d_o.oe_n[D_SDO] && pin_d_o.val[D_SDO] == $past(per_drv_i.sdo)
        && (pin_c_o.oe_n[C_RX] || $past(per_drv_i.uart_en)))
        else $error("Alternate serial data out misrouted.");

    a_pwm_claim: assert property (@(posedge clk_i) disable iff (rst_i)
        per_drv_i.pwm_en[2] |=> !pin_d_o.oe_n[D_PWM7] && pin_d_o.val[D_PWM7] == $past(per_drv_i.pwm[2]))
        else $error("PWM 7 not on its pin.");

    a_clk_select: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_r[CFG_EXCLK] |=> per_rcv_o.t0_clk == $past(lvl_d_r[D_EXCLK]))
        else $error("Timer clock taken from the wrong pin.");

endmodule : gpm_port

// ===== bench/gpm_board.sv
// Purpose: Board side of both pin banks, resolving each pin from device and board drivers.
// Assumes: The board drives every pin that the device leaves floating.
// Notes:   Contention is not modelled; a driven pin always shows the device value.
`timescale 1ns/1ns
module gpm_board (
    input  wire gpm_pkg::gpm_pins_t pin_c_o,
    input  wire gpm_pkg::gpm_pins_t pin_d_o,
    input  wire logic [7:0]         ext_c_i,
    input  wire logic [7:0]         ext_d_i,
    output logic      [7:0]         pin_c_o_lvl,
    output logic      [7:0]         pin_d_o_lvl
);
    // Each pin shows the device value where its driver is on, else the board level.
    always_comb begin
        pin_c_o_lvl = (~pin_c_o.oe_n & pin_c_o.val) | (pin_c_o.oe_n & ext_c_i);
        pin_d_o_lvl = (~pin_d_o.oe_n & pin_d_o.val) | (pin_d_o.oe_n & ext_d_i);
    end
endmodule : gpm_board

// ===== bench/tb.sv
// Purpose: Self-checking bench for the dual port pin multiplexer.
// Assumes: Classic Wishbone, one ack per request, pin levels settle within eight edges.
// Notes:   Latch values are read after a mid-run reset to prove they survive it.
`timescale 1ns/1ns
module tb;
    import gpm_pkg::*;
    logic               clk_i    = 1'b0;
    logic               rst_i    = 1'b1;
    logic               wb_cyc_i = 1'b0;
    logic               wb_stb_i = 1'b0;
    logic               wb_we_i  = 1'b0;
    logic [ADR_W-1:0]   wb_adr_i = '0;
    logic [SEL_W-1:0]   wb_sel_i = '0;
    logic [DAT_W-1:0]   wb_dat_i = '0;
    logic [DAT_W-1:0]   wb_dat_o;
    logic               wb_ack_o;
    logic [7:0]         pin_c_i;
    logic [7:0]         pin_d_i;
    logic [7:0]         ext_c    = 8'h00;
    logic [7:0]         ext_d    = 8'h00;
    gpm_pins_t          pin_c_o;
    gpm_pins_t          pin_d_o;
    gpm_per_drv_t       drv      = '0;
    gpm_per_rcv_t       rcv;
    int                 fail_count = 0;
    int                 compares   = 0;

    // Free running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    gpm_port i_gpm_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_c_i(pin_c_i),
        .pin_d_i(pin_d_i), .pin_c_o(pin_c_o), .pin_d_o(pin_d_o), .per_drv_i(drv),
        .per_rcv_o(rcv));

    gpm_board i_gpm_board (.pin_c_o(pin_c_o), .pin_d_o(pin_d_o), .ext_c_i(ext_c),
        .ext_d_i(ext_d), .pin_c_o_lvl(pin_c_i), .pin_d_o_lvl(pin_d_i));

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    // One comparison; case inequality so that an unknown never matches.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One classic cycle; the request holds until ack is sampled high, then drops.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [31:0] rd);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h00_0000, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            conclude();
        end
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] x;
        wb(1'b1, adr, d, x);
    endtask : wr

    task automatic rdc(input string name, input logic [7:0] adr, input logic [7:0] e);
        logic [31:0] x;
        wb(1'b0, adr, 8'h00, x);
        chk(name, x, {24'h00_0000, e});
    endtask : rdc

    // Directions come up as all inputs with every driver off.
    task automatic t_reset();
        rdc("c_dir", OFS_C_DIR, 8'hFF);
        rdc("d_dir", OFS_D_DIR, 8'hFF);
        chk("c_oe_n", pin_c_o.oe_n, 8'hFF);
        chk("d_oe_n", pin_d_o.oe_n, 8'hFF);
    endtask : t_reset

    // Bank C drives its latch, floats inputs, and reads latch apart from pins.
    task automatic t_bank_c();
        ext_c <= 8'hA3;
        wr(OFS_C_LAT, 8'h55);
        rdc("c_lat", OFS_C_LAT, 8'h55);
        wr(OFS_C_DIR, 8'h00);
        repeat (2) @(posedge clk_i);
        chk("c_oe_n", pin_c_o.oe_n, 8'h00);
        chk("c_val", pin_c_o.val, 8'h55);
        wr(OFS_C_DIR, 8'h0F);
        repeat (8) @(posedge clk_i);
        chk("c_oe_n", pin_c_o.oe_n, 8'h0F);
        // Upper nibble driven from the latch, lower nibble from the board.
        rdc("c_pin", OFS_C_PIN, 8'h53);
        rdc("c_lat", OFS_C_LAT, 8'h55);
    endtask : t_bank_c

    // Bank D: the pin register write lands in the latch.
    task automatic t_bank_d();
        ext_d <= 8'h3C;
        wr(OFS_D_PIN, 8'hC3);
        rdc("d_lat", OFS_D_LAT, 8'hC3);
        wr(OFS_D_DIR, 8'hF0);
        repeat (8) @(posedge clk_i);
        chk("d_oe_n", pin_d_o.oe_n, 8'hF0);
        chk("d_val", pin_d_o.val[3:0], 4'h3);
        rdc("d_pin", OFS_D_PIN, 8'h33);
        rdc("d_lat", OFS_D_LAT, 8'hC3);
    endtask : t_bank_d

    // A transceiver drive overrides the direction bit without changing it.
    task automatic t_override();
        wr(OFS_C_DIR, 8'hFF);
        drv.uart_en <= 1'b1;
        drv.tx_oe   <= 1'b1;
        drv.tx      <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("c6_oe_n", pin_c_o.oe_n[C_TX], 1'b0);
        chk("c6_val", pin_c_o.val[C_TX], 1'b1);
        rdc("c_dir", OFS_C_DIR, 8'hFF);
        drv   <= '0;
        ext_c <= 8'h28;
        repeat (8) @(posedge clk_i);
        chk("ext_int", rcv.ext_int, 3'b101);
    endtask : t_override

    // Alternate locations move serial data out and PWM output 4 onto bank D.
    task automatic t_route();
        wr(OFS_D_DIR, 8'hFF);
        wr(OFS_CFG, 8'h09);
        drv.ssp_en <= 1'b1;
        drv.sdo_oe <= 1'b1;
        drv.sdo    <= 1'b1;
        drv.pwm_en <= 3'b111;
        drv.pwm    <= 3'b111;
        repeat (3) @(posedge clk_i);
        chk("d1", {pin_d_o.oe_n[D_SDO], pin_d_o.val[D_SDO]}, 2'b01);
        chk("c7_oe_n", pin_c_o.oe_n[C_RX], 1'b1);
        chk("d5", {pin_d_o.oe_n[D_PWM4], pin_d_o.val[D_PWM4]}, 2'b01);
        chk("d6", {pin_d_o.oe_n[D_PWM6], pin_d_o.val[D_PWM6]}, 2'b01);
        chk("d7", {pin_d_o.oe_n[D_PWM7], pin_d_o.val[D_PWM7]}, 2'b01);
        drv <= '0;
        wr(8'h40, 8'hAA);
        rdc("unmapped", 8'h40, 8'h00);
    endtask : t_route

    // A mid-run reset restores directions but keeps the latches.
    task automatic t_rerst();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("c_lat", OFS_C_LAT, 8'h55);
        rdc("c_dir", OFS_C_DIR, 8'hFF);
    endtask : t_rerst

    // Inputs reach the peripherals at primary and alternate pins; C0-C2 overrides.
    task automatic t_inputs();
        ext_c <= 8'hC6;
        ext_d <= 8'h01;
        repeat (8) @(posedge clk_i);
        chk("fault_a", rcv.fault_a, 1'b1);
        chk("fault_b", rcv.fault_b, 1'b1);
        chk("ss", rcv.ss, 1'b1);
        chk("rx", rcv.rx, 1'b1);
        chk("t0_clk", rcv.t0_clk, 1'b0);
        chk("capture_compare_unit2_in", rcv.capture_compare_unit2_in, 1'b1);
        chk("t1_osc_in", rcv.t1_osc_in, 1'b1);
        chk("capture_compare_unit1_in", rcv.capture_compare_unit1_in, 1'b1);
        chk("sdi", rcv.sdi, 1'b0);
        wr(OFS_CFG, 8'h16);
        repeat (3) @(posedge clk_i);
        chk("t0_alt", rcv.t0_clk, 1'b1);
        chk("t5_alt", rcv.t5_clk, 1'b1);
        chk("fault_a_alt", rcv.fault_a, 1'b0);
        chk("capture_compare_unit2_alt", rcv.capture_compare_unit2_in, 1'b0);
        wr(OFS_CFG, 8'h00);
        wr(OFS_C_DIR, 8'h00);
        drv.t1osc_en <= 1'b1;
        drv.capture_compare_unit1_oe  <= 1'b1;
        drv.capture_compare_unit1_o   <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("c10_oe_n", pin_c_o.oe_n[1:0], 2'b11);
        chk("c2", {pin_c_o.oe_n[C_CAPTURE_COMPARE_UNIT1], pin_c_o.val[C_CAPTURE_COMPARE_UNIT1]}, 2'b00);
        drv <= '0;
        wr(OFS_C_DIR, 8'hFF);
    endtask : t_inputs

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_bank_c();
        t_bank_d();
        t_override();
        t_route();
        t_rerst();
        t_inputs();
        conclude();
    end
endmodule : tb
